// File: hw/ftm_defs.vh
`ifndef FTM_DEFS_VH
`define FTM_DEFS_VH

// register offsets
`define FTM_ADDR_CONFIG1      8'h00
`define FTM_ADDR_PIN_SELECT   8'h01
`define FTM_ADDR_PRESCALE_LO  8'h02
`define FTM_ADDR_PRESCALE_HI  8'h03
`define FTM_ADDR_FAN_MASK     8'h1A
`define FTM_ADDR_FAN_STATUS   8'h22
`define FTM_ADDR_FAN_VALUE0   8'h38
`define FTM_ADDR_FAN_LIMIT0   8'h60

// config1 field positions
`define FTM_CFG_MONITOR_BIT   0
`define FTM_CFG_INT_EN_BIT    1
`define FTM_CFG_INT_CLR_BIT   2

// reset values and full-scale count
`define FTM_RST_CONFIG1       8'h00
`define FTM_RST_PIN_SELECT    8'h00
`define FTM_RST_PRESCALE      8'h55
`define FTM_RST_FAN_MASK      8'h00
`define FTM_RST_FAN_LIMIT     8'hFF
`define FTM_COUNT_FULL        8'hFF

// timing
`define FTM_CLK_HZ            25000000
`define FTM_OSC_HZ            22500
`define FTM_OSC_DIV           (`FTM_CLK_HZ / `FTM_OSC_HZ)
`define FTM_SPINUP_MS         1800
`define FTM_SPINUP_CYCLES     (`FTM_SPINUP_MS * (`FTM_CLK_HZ / 1000))

`endif

// File: hw/ftm_tach_edge.v
`timescale 1ns/1ps
`default_nettype none

module ftm_tach_edge (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] tach,
    output wire [7:0] rise
);
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_ch
            reg meta;
            reg sync;
            reg last;
            always @(posedge mclk or negedge rst_n) begin
                // pins idle high on their pull-ups; resetting to one avoids a false edge
                if (!rst_n) begin
                    meta <= 1'b1;
                    sync <= 1'b1;
                    last <= 1'b1;
                end else begin
                    meta <= tach[i];
                    sync <= meta;
                    last <= sync;
                end
            end
            assign rise[i] = sync & ~last;
        end
    endgenerate
endmodule // ftm_tach_edge

`default_nettype wire

// File: hw/ftm_fan_monitor.v
`timescale 1ns/1ps
`default_nettype none
`include "ftm_defs.vh"

module ftm_fan_monitor #(
    parameter SPINUP_CYCLES = `FTM_SPINUP_CYCLES
) (
    input wire mclk,
    input wire arst_n,
    input wire [7:0] tach,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    output reg [7:0] reg_rdata,
    output reg [7:0] pin_logic_sel,
    output reg analog_start,
    output reg alert_n
);
    localparam ST_IDLE = 2'd0;
    localparam ST_SPIN = 2'd1;
    localparam ST_INIT = 2'd2;
    localparam ST_MEAS = 2'd3;

    reg rst_meta;
    reg rst_n;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    wire [7:0] rise;
    ftm_tach_edge u_edge (
        .mclk(mclk),
        .rst_n(rst_n),
        .tach(tach),
        .rise(rise)
    );

    reg [7:0] config1;
    reg [7:0] prescale_lo;
    reg [7:0] prescale_hi;
    reg [7:0] fan_mask;
    reg [7:0] fan_status;
    reg [7:0] fan_value [0:7];
    reg [7:0] fan_limit [0:7];
    reg [1:0] state;
    reg [2:0] chan;
    reg [7:0] count;
    reg edge_seen;
    reg [10:0] osc_div;
    reg osc_tick;
    reg [2:0] pre_cnt;
    reg [31:0] spin_cnt;
    reg alert_latch;
    reg alert_armed;
    integer k;

    wire wr_cfg = reg_wr && (reg_addr == `FTM_ADDR_CONFIG1);
    wire start = wr_cfg && reg_wdata[`FTM_CFG_MONITOR_BIT]
        && !config1[`FTM_CFG_MONITOR_BIT];
    wire monitor = config1[`FTM_CFG_MONITOR_BIT];
    wire int_clear = config1[`FTM_CFG_INT_CLR_BIT];

    // two divisor bits per fan, code 0..3 means divide by 1, 2, 4, 8
    wire [7:0] pre_reg = chan[2] ? prescale_hi : prescale_lo;
    wire [1:0] div_code = pre_reg[{chan[1:0], 1'b0} +: 2];
    wire [2:0] div_mask = (div_code == 2'd0) ? 3'd0 :
                          (div_code == 2'd1) ? 3'd1 :
                          (div_code == 2'd2) ? 3'd3 : 3'd7;
    wire cnt_tick = osc_tick && ((pre_cnt & div_mask) == div_mask);
    // logic-configured pins never deliver an edge, so the slot runs to full scale
    wire tach_edge = rise[chan] && !pin_logic_sel[chan];
    // end on the tick that brings the count to full scale, so a slot lasts 255 ticks
    wire last_step = (count == (`FTM_COUNT_FULL - 8'h01));
    wire timeout = cnt_tick && last_step;
    wire done_ok = (state == ST_MEAS) && tach_edge && edge_seen;
    wire chan_end = (state == ST_INIT || state == ST_MEAS) && (timeout || done_ok);
    wire [7:0] result = (done_ok && !timeout) ? count : `FTM_COUNT_FULL;

    // free-running on-chip oscillator tick
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            osc_div <= 11'd0;
            osc_tick <= 1'b0;
        end else if (osc_div == (`FTM_OSC_DIV - 1)) begin
            osc_div <= 11'd0;
            osc_tick <= 1'b1;
        end else begin
            osc_div <= osc_div + 11'd1;
            osc_tick <= 1'b0;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            config1 <= `FTM_RST_CONFIG1;
            pin_logic_sel <= `FTM_RST_PIN_SELECT;
            prescale_lo <= `FTM_RST_PRESCALE;
            prescale_hi <= `FTM_RST_PRESCALE;
            fan_mask <= `FTM_RST_FAN_MASK;
            analog_start <= 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                fan_limit[k] <= `FTM_RST_FAN_LIMIT;
            end
        end else begin
            analog_start <= start;
            if (reg_wr) begin
                if (reg_addr == `FTM_ADDR_CONFIG1) begin
                    config1 <= reg_wdata;
                end else if (reg_addr == `FTM_ADDR_PIN_SELECT) begin
                    pin_logic_sel <= reg_wdata;
                end else if (reg_addr == `FTM_ADDR_PRESCALE_LO) begin
                    prescale_lo <= reg_wdata;
                end else if (reg_addr == `FTM_ADDR_PRESCALE_HI) begin
                    prescale_hi <= reg_wdata;
                end else if (reg_addr == `FTM_ADDR_FAN_MASK) begin
                    fan_mask <= reg_wdata;
                end else if (reg_addr[7:3] == `FTM_ADDR_FAN_LIMIT0 >> 3) begin
                    fan_limit[reg_addr[2:0]] <= reg_wdata;
                end
            end
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            chan <= 3'd0;
            count <= 8'h00;
            edge_seen <= 1'b0;
            pre_cnt <= 3'd0;
            spin_cnt <= 32'd0;
            fan_status <= 8'h00;
            for (k = 0; k < 8; k = k + 1) begin
                fan_value[k] <= 8'h00;
            end
        end else if (start) begin
            state <= ST_SPIN;
            spin_cnt <= 32'd0;
            chan <= 3'd0;
            for (k = 0; k < 8; k = k + 1) begin
                fan_value[k] <= 8'h00;
            end
        end else if (!monitor) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_SPIN: begin
                    if (spin_cnt == SPINUP_CYCLES - 1) begin
                        state <= ST_INIT;
                        count <= 8'h00;
                        edge_seen <= 1'b0;
                        pre_cnt <= 3'd0;
                    end else begin
                        spin_cnt <= spin_cnt + 32'd1;
                    end
                end
                ST_INIT, ST_MEAS: begin
                    if (osc_tick) begin
                        pre_cnt <= pre_cnt + 3'd1;
                    end
                    if (chan_end) begin
                        fan_value[chan] <= result;
                        fan_status[chan] <= (result > fan_limit[chan]);
                        chan <= chan + 3'd1;
                        state <= ST_INIT;
                        count <= 8'h00;
                        edge_seen <= 1'b0;
                        pre_cnt <= 3'd0;
                    end else if (tach_edge && edge_seen && state == ST_INIT) begin
                        state <= ST_MEAS;
                        count <= 8'h00;
                        edge_seen <= 1'b0;
                    end else begin
                        if (tach_edge) begin
                            edge_seen <= 1'b1;
                        end
                        if (cnt_tick) begin
                            count <= count + 8'd1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // a cleared alert stays quiet until the running fan cycle wraps past fan 7
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alert_latch <= 1'b0;
            alert_armed <= 1'b1;
            alert_n <= 1'b1;
        end else begin
            if (int_clear) begin
                alert_latch <= 1'b0;
                alert_armed <= 1'b0;
            end else begin
                if (chan_end && chan == 3'd7) begin
                    alert_armed <= 1'b1;
                end
                if (alert_armed && |(fan_status & ~fan_mask)) begin
                    alert_latch <= 1'b1;
                end
            end
            // the pin is live only with enable set and clear released
            alert_n <= ~(alert_latch && config1[`FTM_CFG_INT_EN_BIT] && !int_clear);
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr == `FTM_ADDR_CONFIG1) begin
            reg_rdata <= config1;
        end else if (reg_addr == `FTM_ADDR_PIN_SELECT) begin
            reg_rdata <= pin_logic_sel;
        end else if (reg_addr == `FTM_ADDR_PRESCALE_LO) begin
            reg_rdata <= prescale_lo;
        end else if (reg_addr == `FTM_ADDR_PRESCALE_HI) begin
            reg_rdata <= prescale_hi;
        end else if (reg_addr == `FTM_ADDR_FAN_MASK) begin
            reg_rdata <= fan_mask;
        end else if (reg_addr == `FTM_ADDR_FAN_STATUS) begin
            reg_rdata <= fan_status;
        end else if (reg_addr[7:3] == `FTM_ADDR_FAN_VALUE0 >> 3) begin
            reg_rdata <= (state == ST_SPIN) ? 8'h00 : fan_value[reg_addr[2:0]];
        end else if (reg_addr[7:3] == `FTM_ADDR_FAN_LIMIT0 >> 3) begin
            reg_rdata <= fan_limit[reg_addr[2:0]];
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // ftm_fan_monitor

`default_nettype wire

// File: verif/ftm_fan_chk_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ftm_fan_monitor_chk #(
    parameter SPINUP_CYCLES = 2000
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] tach,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] pin_logic_sel,
    input wire logic analog_start,
    input wire logic alert_n
);
    logic mon, int_en, clr, wr_d, start_d;
    logic [7:0] rd_addr;
    int spin;
    wire cfg_wr = reg_wr && reg_addr == 8'h00;
    wire sel_wr = reg_wr && reg_addr == 8'h01;
    wire start_wr = cfg_wr && reg_wdata[0] && !mon;
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mon <= 1'b0;
            int_en <= 1'b0;
            clr <= 1'b0;
            wr_d <= 1'b0;
            start_d <= 1'b0;
            rd_addr <= 8'h00;
            spin <= 0;
        end else begin
            mon <= cfg_wr ? reg_wdata[0] : mon;
            int_en <= cfg_wr ? reg_wdata[1] : int_en;
            clr <= cfg_wr ? reg_wdata[2] : clr;
            wr_d <= reg_wr;
            start_d <= start_wr;
            rd_addr <= reg_addr;
            spin <= start_wr ? SPINUP_CYCLES : (spin > 0 ? spin - 1 : 0);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence start_s;
        cfg_wr && reg_wdata[0] && !mon;
    endsequence
    sequence quiet_s;
        !int_en [*2];
    endsequence
    start_pulse_a: assert property (start_s |=> analog_start)
        else $error("no start pulse");
    pulse_single_a: assert property (analog_start |=> !analog_start)
        else $error("long start");
    start_cause_a: assert property (analog_start |-> start_d)
        else $error("stray start");
    sel_write_a: assert property (sel_wr |=> pin_logic_sel == $past(reg_wdata))
        else $error("select not written");
    sel_hold_a: assert property (!sel_wr |=> $stable(pin_logic_sel))
        else $error("select moved");
    sel_read_a: assert property (
        rd_addr == 8'h01 && !wr_d |-> reg_rdata == pin_logic_sel)
        else $error("select readback");
    spinup_zero_a: assert property (
        spin > 2 && rd_addr[7:3] == 5'h07 |-> reg_rdata == 8'h00)
        else $error("value during spin-up");
    alert_gate_a: assert property (quiet_s |-> alert_n)
        else $error("alert while disabled");
    alert_cause_a: assert property ($fell(alert_n) |-> $past(int_en))
        else $error("alert cause");
    clear_hold_a: assert property (clr |=> alert_n)
        else $error("alert during clear");
endmodule // ftm_fan_monitor_chk
bind ftm_fan_monitor ftm_fan_monitor_chk #(.SPINUP_CYCLES(SPINUP_CYCLES)) u_chk (
    .mclk(mclk), .arst_n(arst_n), .tach(tach), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .pin_logic_sel(pin_logic_sel),
    .analog_start(analog_start), .alert_n(alert_n));
`default_nettype wire

// File: verif/ftm_fan_model.sv
`timescale 1ns/1ps
`default_nettype none
module ftm_fan_model #(
    parameter int TICK = 1111
) (
    input wire logic mclk,
    output logic [7:0] tach
);
    // odd fans are half as fast, so a shifted channel order shows in the counts
    int cnt [8];
    always @(posedge mclk) begin
        for (int n = 0; n < 8; n++) begin
            cnt[n] <= (cnt[n] >= TICK * (1 + n % 2) - 1) ? 0 : cnt[n] + 1;
            tach[n] <= cnt[n] < TICK * (1 + n % 2) / 2;
        end
    end
endmodule // ftm_fan_model
`default_nettype wire

// File: verif/fan_tach_period_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fan_tach_period_monitor_tb;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    wire [7:0] tach, reg_rdata, pin_logic_sel;
    wire analog_start, alert_n;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int e;
    logic ok;
    logic [7:0] v;
    logic [15:0] rows [9] = '{16'h0000, 16'h0100, 16'h0255, 16'h0355, 16'h1A00, 16'h2200,
        16'h3800, 16'h60FF, 16'h0400};
    ftm_fan_model u_fans (.mclk(mclk), .tach(tach));
    ftm_fan_monitor #(.SPINUP_CYCLES(2000)) u_dut (.mclk(mclk), .arst_n(arst_n), .tach(tach),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .pin_logic_sel(pin_logic_sel), .analog_start(analog_start), .alert_n(alert_n));
    always #20 mclk = ~mclk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        @(posedge mclk);
        #1;
        d = reg_rdata;
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (rows[i]) begin
            rd(rows[i][15:8], v);
            check(v, rows[i][7:0]);
        end
        $display("reset values done");
        wr(8'h01, 8'hA5);
        rd(8'h01, v);
        check(v, 8'hA5);
        check(pin_logic_sel, 8'hA5);
        wr(8'h01, 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h03, 8'h00);
        wr(8'h61, 8'h02);
        rd(8'h02, v);
        check(v, 8'h00);
        wr(8'h00, 8'h03);
        rd(8'h38, v);
        check(v, 8'h00);
        $display("start and spin-up done");
        while (v === 8'h00) rd(8'h3F, v);
        for (int n = 0; n < 8; n++) begin
            rd(8'h38 + n[7:0], v);
            e = 2 + 2 * (n % 2);
            ok = (v >= e - 1) && (v <= e + 1);
            check({7'h00, ok}, 8'h01);
        end
        rd(8'h22, v);
        check(v, 8'h02);
        check({7'h00, alert_n}, 8'h00);
        $display("measurement done");
        wr(8'h00, 8'h07);
        repeat (2) @(posedge mclk);
        #1;
        check({7'h00, alert_n}, 8'h01);
        wr(8'h00, 8'h03);
        repeat (4) @(posedge mclk);
        #1;
        check({7'h00, alert_n}, 8'h01);
        $display("alert clear done");
        // a halted loop keeps its last values; only a new start or a reset clears them
        wr(8'h00, 8'h00);
        rd(8'h38, v);
        ok = (v >= 8'h01) && (v <= 8'h03);
        check({7'h00, ok}, 8'h01);
        wr(8'h00, 8'h01);
        #1;
        check({7'h00, analog_start}, 8'h01);
        rd(8'h38, v);
        check(v, 8'h00);
        $display("halt and restart done");
        wr(8'h01, 8'h0F);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(8'h01, v);
        check(v, 8'h00);
        check(pin_logic_sel, 8'h00);
        rd(8'h00, v);
        check(v, 8'h00);
        check({7'h00, alert_n}, 8'h01);
        $display("mid-run reset done");
        test_done();
    end
endmodule // fan_tach_period_monitor_tb
`default_nettype wire
